// [sleep_wdt_ctrl.sv]
// sleep entry and wake-up sequencer with watchdog, apb register slave
// core and interrupt logic are on pclk; lf_tick is a synchronous one-cycle tick
//
// Notes on behaviour
// - power-down is entered only on the sleep instruction
// - sleep entry clears watchdog, clears powerdown, sets timeout, stops cpu clock
// - low-frequency oscillator keeps running throughout sleep
// - io ports hold their pre-sleep state during sleep
// - converter keeps running in sleep when its own oscillator is chosen
// - sleep leaves every non-watchdog reset source unchanged
// - pin, brownout, power-on reset; watchdog and interrupts resume execution
// - next instruction is prefetched while the sleep instruction executes
// - individually enabled interrupts wake regardless of global enable
// - after interrupt wake, vector only when global enable is set
// - watchdog cleared on every wake from sleep
// - interrupt pending before sleep makes sleep a no-op, flags untouched
// - interrupt during or after sleep: complete entry then wake at once
// - power select bit puts regulator in low-power state during sleep
// - low-power wake adds a stabilisation delay; normal wake has none
// - incompatible peripheral enabled keeps regulator in normal mode
// - high-frequency oscillator kept running in sleep when a user needs it
// - watchdog time base is the low-frequency oscillator tick
// - watchdog resets device when not cleared within the time-out
// - mode 11 always on, 10 off in sleep, 01 software enable
// - watchdog time-out in sleep wakes instead of resetting
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
module sleep_wdt_ctrl
  import sleep_wdt_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration word and oscillator tick
  input wire logic [1:0] watchdog_mode_config,
  input wire logic lf_tick,
  // core, reset sources and peripheral conditions
  input wire core_req_t core_req,
  input wire reset_src_t reset_src,
  input wire periph_cond_t periph,
  // outputs to chip and core
  output pwr_ctl_t pwr_ctl,
  output core_evt_t core_evt
);

  // the wake-delay check below counts on at least this many settle cycles
  localparam int SETTLE_MIN = 2;

  if (STAB_COUNT < SETTLE_MIN || STAB_COUNT >= (1 << STAB_W)) begin : g_bad_stab
    $error("STAB_COUNT out of range");
  end

  localparam logic [STAB_W-1:0] STAB_LOAD = STAB_W'(STAB_COUNT - 1);

  typedef struct packed {
    pwr_state_t fsm;
    logic [WDT_W-1:0] wdt_cnt;
    logic [STAB_W-1:0] settle_cnt;
    logic timeout_flag;
    logic powerdown_flag;
    logic power_sel;
    logic sw_enable;
    logic [4:0] period_sel;
    logic lp_active;
    logic woke_irq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    pwr_ctl_t ctl;
    core_evt_t evt;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  function automatic logic [WDT_W-1:0] wdt_limit(input logic [4:0] ps);
    // reserved period codes fall back to the shortest interval
    if (ps > PS_MAX) begin
      return WDT_BASE;
    end
    return WDT_BASE << ps;
  endfunction

  function automatic logic wdt_active(input logic [1:0] mode, input logic swen,
                                      input logic asleep);
    case (mode)
      WDT_MODE_ON: return 1'b1;
      WDT_MODE_AWAKE: return !asleep;
      WDT_MODE_SW: return swen;
      default: return 1'b0;
    endcase
  endfunction

  logic wdt_on;
  logic wdt_expire;
  logic full_rst;
  logic do_resume;
  logic setup_ph;
  logic access_wr;

  always_comb begin
    state_nxt = state_r;
    state_nxt.evt = '0;
    do_resume = 1'b0;
    setup_ph = psel && !penable;
    access_wr = psel && penable && pwrite && state_r.ready;
    wdt_on = wdt_active(watchdog_mode_config, state_r.sw_enable, state_r.fsm == ST_ASLEEP);
    wdt_expire = wdt_on && lf_tick && (state_r.wdt_cnt == wdt_limit(state_r.period_sel) - WDT_ONE);
    // resets act the same awake or asleep
    full_rst = (reset_src.ext_pin && reset_src.ext_pin_en) ||
               (reset_src.brownout && reset_src.brownout_en) || reset_src.power_on;

    // apb: data prepared in setup so the access phase completes at once
    state_nxt.ready = 1'b1;
    if (setup_ph) begin
      state_nxt.slverr = 1'b0;
      state_nxt.rdata = '0;
      case (paddr)
        OFS_REG_SLEEP_CTL: begin
          state_nxt.rdata[BIT_RESERVED] = 1'b1;
          state_nxt.rdata[BIT_POWER_SEL] = state_r.power_sel;
        end
        OFS_STATUS: begin
          state_nxt.rdata[BIT_TIMEOUT] = state_r.timeout_flag;
          state_nxt.rdata[BIT_POWERDOWN] = state_r.powerdown_flag;
          state_nxt.rdata[BIT_ASLEEP] = state_r.fsm != ST_AWAKE;
          state_nxt.rdata[BIT_LOW_POWER] = state_r.lp_active;
        end
        OFS_WDT_CTL: begin
          state_nxt.rdata[BIT_SW_ENABLE] = state_r.sw_enable;
          state_nxt.rdata[PS_MSB:PS_LSB] = state_r.period_sel;
        end
        OFS_WDT_COUNT: state_nxt.rdata[WDT_W-1:0] = state_r.wdt_cnt;
        default: state_nxt.slverr = 1'b1;
      endcase
    end
    if (access_wr) begin
      case (paddr)
        OFS_REG_SLEEP_CTL: state_nxt.power_sel = pwdata[BIT_POWER_SEL];
        OFS_WDT_CTL: begin
          state_nxt.sw_enable = pwdata[BIT_SW_ENABLE];
          state_nxt.period_sel = pwdata[PS_MSB:PS_LSB];
        end
        default: state_nxt.power_sel = state_r.power_sel;
      endcase
    end

    // watchdog counting; disabled means held cleared
    if (!wdt_on) begin
      state_nxt.wdt_cnt = '0;
    end else if (lf_tick) begin
      state_nxt.wdt_cnt = wdt_expire ? '0 : state_r.wdt_cnt + WDT_ONE;
    end

    case (state_r.fsm)
      ST_AWAKE: begin
        if (core_req.sleep_instr) begin
          state_nxt.evt.prefetch = 1'b1;
        end
        if (core_req.sleep_instr && core_req.irq_pending) begin
          state_nxt.wdt_cnt = state_r.wdt_cnt;
        end else if (core_req.sleep_instr) begin
          state_nxt.fsm = ST_ASLEEP;
          state_nxt.wdt_cnt = '0;
          state_nxt.powerdown_flag = 1'b0;
          state_nxt.timeout_flag = 1'b1;
          state_nxt.ctl.cpu_clk_en = 1'b0;
          state_nxt.ctl.io_hold = 1'b1;
          state_nxt.lp_active = state_r.power_sel && !periph.lp_incompatible;
        end else if (wdt_expire) begin
          // awake time-out resets; beats a clear in the same cycle
          state_nxt.evt.wdt_reset = 1'b1;
          state_nxt.timeout_flag = 1'b0;
        end else if (core_req.clear_instr) begin
          state_nxt.wdt_cnt = '0;
          state_nxt.timeout_flag = 1'b1;
          state_nxt.powerdown_flag = 1'b1;
        end
      end
      ST_ASLEEP: begin
        // wake sources; pending already gated by enables
        if (core_req.irq_pending || wdt_expire) begin
          state_nxt.wdt_cnt = '0;
          state_nxt.woke_irq = core_req.irq_pending;
          if (wdt_expire) begin
            state_nxt.timeout_flag = 1'b0;
          end
          // low-power regulator needs time to settle
          if (state_r.lp_active) begin
            state_nxt.fsm = ST_SETTLE;
            state_nxt.settle_cnt = STAB_LOAD;
          end else begin
            do_resume = 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        if (state_r.settle_cnt == '0) begin
          do_resume = 1'b1;
        end else begin
          state_nxt.settle_cnt = state_r.settle_cnt - 1'b1;
        end
      end
      default: state_nxt.fsm = ST_AWAKE;
    endcase

    if (do_resume) begin
      state_nxt.fsm = ST_AWAKE;
      state_nxt.ctl.cpu_clk_en = 1'b1;
      state_nxt.ctl.io_hold = 1'b0;
      state_nxt.lp_active = 1'b0;
      state_nxt.evt.resume = 1'b1;
      // vector only with global enable, after the next instruction
      state_nxt.evt.vector_req = (state_nxt.woke_irq || core_req.irq_pending) && core_req.global_interrupt_enable;
    end

    state_nxt.ctl.lf_osc_keep = 1'b1;
    state_nxt.ctl.adc_run_en = (state_nxt.fsm == ST_AWAKE) || periph.adc_conv_osc_sel;
    state_nxt.ctl.hf_osc_keep = (state_nxt.fsm == ST_AWAKE) || periph.hf_osc_needed;
    state_nxt.ctl.reg_low_power = (state_nxt.fsm == ST_ASLEEP) && state_nxt.lp_active &&
                                  !periph.lp_incompatible;

    if (full_rst) begin
      // full reset from pin, brownout or power-on
      state_nxt.fsm = ST_AWAKE;
      state_nxt.wdt_cnt = '0;
      state_nxt.timeout_flag = 1'b1;
      state_nxt.powerdown_flag = 1'b1;
      state_nxt.lp_active = 1'b0;
      state_nxt.ctl.cpu_clk_en = 1'b1;
      state_nxt.ctl.io_hold = 1'b0;
      state_nxt.ctl.reg_low_power = 1'b0;
      state_nxt.evt = '0;
      state_nxt.evt.full_reset = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
      state_r.fsm <= ST_AWAKE;
      state_r.timeout_flag <= 1'b1;
      state_r.powerdown_flag <= 1'b1;
      state_r.period_sel <= PS_RESET;
      state_r.ctl.cpu_clk_en <= 1'b1;
      state_r.ctl.lf_osc_keep <= 1'b1;
      state_r.ctl.adc_run_en <= 1'b1;
      state_r.ctl.hf_osc_keep <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.rdata;
  assign pready = state_r.ready;
  assign pslverr = state_r.slverr;
  assign pwr_ctl = state_r.ctl;
  assign core_evt = state_r.evt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sleep_ok;
    state_r.fsm == ST_AWAKE && core_req.sleep_instr && !core_req.irq_pending && !full_rst;
  endsequence

  sequence s_sleep_noop;
    state_r.fsm == ST_AWAKE && core_req.sleep_instr && core_req.irq_pending && !full_rst;
  endsequence

  sequence s_lp_wake;
    state_r.fsm == ST_ASLEEP && state_r.lp_active && core_req.irq_pending && !full_rst;
  endsequence

  a_sleep_entry_flags: assert property (s_sleep_ok |=>
    state_r.fsm == ST_ASLEEP && !state_r.powerdown_flag && state_r.timeout_flag &&
    !pwr_ctl.cpu_clk_en && state_r.wdt_cnt == '0)
    else $error("sleep entry effects missing");

  a_noop_sleep_flags: assert property (s_sleep_noop |=>
    state_r.fsm == ST_AWAKE && $stable(state_r.timeout_flag) && $stable(state_r.powerdown_flag))
    else $error("pending interrupt did not make sleep a no-op");

  a_sleep_prefetch: assert property (state_r.fsm == ST_AWAKE && core_req.sleep_instr &&
    !full_rst |=> core_evt.prefetch)
    else $error("no prefetch on sleep instruction");

  a_io_held_asleep: assert property (state_r.fsm != ST_AWAKE |-> pwr_ctl.io_hold &&
    pwr_ctl.lf_osc_keep)
    else $error("pads or slow oscillator released in sleep");

  a_regulator_lp_gate: assert property (pwr_ctl.reg_low_power |-> state_r.power_sel &&
    state_r.fsm == ST_ASLEEP)
    else $error("regulator low power without selection");

  // repetition count is SETTLE_MIN written out
  a_lp_wake_delay: assert property (s_lp_wake ##1 (!full_rst)[*2] |->
    !pwr_ctl.cpu_clk_en)
    else $error("low-power wake skipped settling");

  a_normal_wake_fast: assert property (state_r.fsm == ST_ASLEEP && !state_r.lp_active &&
    core_req.irq_pending && !full_rst |=> pwr_ctl.cpu_clk_en && core_evt.resume)
    else $error("normal wake not immediate");

  a_vector_needs_gie: assert property (core_evt.vector_req |-> $past(core_req.global_interrupt_enable))
    else $error("vector without global enable");

  a_sleep_timeout_wake: assert property (state_r.fsm == ST_ASLEEP && wdt_expire &&
    !full_rst |=> !core_evt.wdt_reset && !state_r.timeout_flag)
    else $error("sleep time-out reset the device");

  a_mode_off_clear: assert property (watchdog_mode_config == WDT_MODE_OFF |=>
    state_r.wdt_cnt == '0 && !core_evt.wdt_reset)
    else $error("watchdog counted while disabled");

  a_reserved_reads_one: assert property (setup_ph && paddr == OFS_REG_SLEEP_CTL |=>
    prdata[BIT_RESERVED])
    else $error("reserved bit read as zero");

  a_wake_clears_wdt: assert property (state_r.fsm == ST_ASLEEP && !full_rst &&
    (core_req.irq_pending || wdt_expire) |=> state_r.wdt_cnt == '0)
    else $error("watchdog not cleared on wake");

endmodule

// [sleep_wdt_pkg.sv]
// constants, register map and carrier types for the sleep and watchdog controller
// assumes a 10 MHz pclk and a one-cycle tick from the low-frequency oscillator
package sleep_wdt_pkg;

  // register byte offsets on the apb window
  localparam logic [7:0] OFS_REG_SLEEP_CTL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WDT_CTL = 8'h08;
  localparam logic [7:0] OFS_WDT_COUNT = 8'h0c;

  // field positions
  localparam int BIT_RESERVED = 0;
  localparam int BIT_POWER_SEL = 1;
  localparam int BIT_TIMEOUT = 0;
  localparam int BIT_POWERDOWN = 1;
  localparam int BIT_ASLEEP = 2;
  localparam int BIT_LOW_POWER = 3;
  localparam int BIT_SW_ENABLE = 0;
  localparam int PS_LSB = 1;
  localparam int PS_MSB = 5;

  // reset value and largest period code
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic [4:0] PS_MAX = 5'h12;

  // watchdog counter: base prescale of 32 ticks, max 2^23 ticks
  localparam int WDT_W = 24;
  localparam logic [WDT_W-1:0] WDT_BASE = 24'h000020;
  localparam logic [WDT_W-1:0] WDT_ONE = 24'h000001;

  // watchdog_mode_config encodings
  localparam logic [1:0] WDT_MODE_OFF = 2'h0;
  localparam logic [1:0] WDT_MODE_SW = 2'h1;
  localparam logic [1:0] WDT_MODE_AWAKE = 2'h2;
  localparam logic [1:0] WDT_MODE_ON = 2'h3;

  // regulator stabilisation after low-power sleep
  localparam int CLK_PERIOD_NS = 100;
  localparam int STAB_TIME_NS = 10000;
  localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_W = 16;

  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_ASLEEP,
    ST_SETTLE
  } pwr_state_t;

  // requests from the processor core and interrupt logic
  typedef struct packed {
    logic sleep_instr;
    logic clear_instr;
    logic irq_pending;
    logic global_interrupt_enable;
  } core_req_t;

  // full reset sources with their enables
  typedef struct packed {
    logic ext_pin;
    logic ext_pin_en;
    logic brownout;
    logic brownout_en;
    logic power_on;
  } reset_src_t;

  // peripheral conditions that steer sleep power
  typedef struct packed {
    logic adc_conv_osc_sel;
    logic lp_incompatible;
    logic hf_osc_needed;
  } periph_cond_t;

  // controls driven to the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic lf_osc_keep;
    logic io_hold;
    logic adc_run_en;
    logic reg_low_power;
    logic hf_osc_keep;
  } pwr_ctl_t;

  // events driven back to the core
  typedef struct packed {
    logic prefetch;
    logic resume;
    logic vector_req;
    logic wdt_reset;
    logic full_reset;
  } core_evt_t;

endpackage

// [core_model.sv]
// model of the processor core and interrupt logic beside the sleep controller
// assumes the sleep and clear commands are one-cycle pulses launched just after a pclk edge
`timescale 1ns/10ps
module core_model
  import sleep_wdt_pkg::*;
(
  // bench commands
  input wire logic do_sleep,
  input wire logic do_clear,
  input wire logic irq,
  input wire logic gie_en,
  // controller side
  input wire pwr_ctl_t pwr_ctl,
  output core_req_t core_req
);
  // a stopped core executes nothing, so instructions need its clock
  // irq is already gated by the individual enables
  assign core_req = '{sleep_instr: do_sleep & pwr_ctl.cpu_clk_en,
                      clear_instr: do_clear & pwr_ctl.cpu_clk_en,
                      irq_pending: irq,
                      global_interrupt_enable: gie_en};
endmodule

// [sleep_wake_and_watchdog_mode_test.sv]
// self-checking bench for the sleep and watchdog controller
// assumes core_model.sv beside it and a 10 MHz pclk
`timescale 1ns/10ps
module sleep_wake_and_watchdog_mode_test;
  import sleep_wdt_pkg::*;
  localparam int STAB = 3;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lf_tick, tick_on;
  logic do_sleep, do_clear, irq, gie_en, err, got, vec;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] mode;
  logic [1:0] div = 2'h0;
  reset_src_t reset_src;
  periph_cond_t periph;
  core_req_t core_req;
  pwr_ctl_t pwr_ctl;
  core_evt_t core_evt;
  wire logic [3:0] evt = {core_evt.prefetch, core_evt.full_reset, core_evt.wdt_reset,
    core_evt.resume};
  int fails, n_tests, n, n0;
  row_t rows[12];
  logic [3:0] mt[5] = '{4'h2, 4'h4, 4'h7, 4'h9, 4'hd};
  logic [4:0] rs[5] = '{5'h10, 5'h18, 5'h04, 5'h06, 5'h01};

  sleep_wdt_ctrl #(.STAB_COUNT(STAB)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_mode_config(mode), .lf_tick(lf_tick),
    .core_req(core_req), .reset_src(reset_src), .periph(periph), .pwr_ctl(pwr_ctl),
    .core_evt(core_evt));
  core_model partner (.do_sleep(do_sleep), .do_clear(do_clear), .irq(irq),
    .gie_en(gie_en), .pwr_ctl(pwr_ctl), .core_req(core_req));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // low-frequency tick every fourth cycle keeps watchdog runs short
  always @(posedge pclk) begin
    div <= div + 2'h1;
    lf_tick <= tick_on && (div == 2'h3);
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // k: 0 resume, 1 watchdog reset, 2 full reset, 3 prefetch
  task automatic wait_ev(input int k, input int lim, input logic must);
    n = 0;
    forever begin
      #1;
      got = (evt[k] === 1'b1);
      if (got || n >= lim) break;
      @(posedge pclk);
      n++;
    end
    if (must && !got) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic core_op(input logic slp);
    @(posedge pclk);
    do_sleep <= slp;
    do_clear <= !slp;
    @(posedge pclk);
    do_sleep <= 1'b0;
    do_clear <= 1'b0;
  endtask

  task automatic irq_wake();
    @(posedge pclk);
    irq <= 1'b1;
    wait_ev(0, 50, 1'b1);
    // vector request stands only with the resume pulse
    vec = core_evt.vector_req;
    @(posedge pclk);
    irq <= 1'b0;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick_on = 1'b0;
    do_sleep = 1'b0;
    do_clear = 1'b0;
    irq = 1'b0;
    gie_en = 1'b0;
    mode = WDT_MODE_OFF;
    reset_src = '0;
    periph = '0;
    rows = '{'{1'b0, OFS_REG_SLEEP_CTL, 32'h0, 32'h1, 1'b0},
      '{1'b0, OFS_STATUS, 32'h0, 32'h3, 1'b0},
      '{1'b0, OFS_WDT_CTL, 32'h0, 32'({PS_RESET, 1'b0}), 1'b0},
      '{1'b0, OFS_WDT_COUNT, 32'h0, 32'h0, 1'b0},
      '{1'b1, OFS_REG_SLEEP_CTL, 32'h1, 32'h0, 1'b0},
      '{1'b0, OFS_REG_SLEEP_CTL, 32'h0, 32'h1, 1'b0},
      '{1'b1, OFS_STATUS, 32'hff, 32'h0, 1'b0},
      '{1'b0, OFS_STATUS, 32'h0, 32'h3, 1'b0},
      '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1},
      '{1'b1, OFS_WDT_CTL, 32'h1, 32'h0, 1'b0},
      '{1'b0, OFS_WDT_CTL, 32'h0, 32'h1, 1'b0},
      '{1'b1, OFS_REG_SLEEP_CTL, 32'h1, 32'h0, 1'b0}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // register writes keep the reserved regulator bit set
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk_bit(err, rows[i].e);
      if (!rows[i].w) chk_word(rd, rows[i].q);
    end
    chk_bit(pwr_ctl.cpu_clk_en, 1'b1);
    $display("register table done");
    for (int g = 1; g >= 0; g--) begin
      gie_en <= g[0];
      periph <= {g[0], 1'b0, g[0]};
      core_op(1'b1);
      wait_ev(3, 3, 1'b1);
      // cpu clock off, slow oscillator kept, pads held
      chk_word(32'(pwr_ctl), {26'h0, 3'b011, g[0], 1'b0, g[0]});
      chk_bit(pwr_ctl.adc_run_en, g[0]);
      chk_bit(pwr_ctl.hf_osc_keep, g[0]);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk_word(rd, 32'h5);
      irq_wake();
      chk_bit(vec, g[0]);
      n0 = n;
    end
    $display("normal sleep done");
    core_op(1'b0);
    irq <= 1'b1;
    core_op(1'b1);
    wait_ev(3, 3, 1'b1);
    chk_bit(pwr_ctl.cpu_clk_en, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_word(rd, 32'h3);
    irq <= 1'b0;
    $display("no-op sleep done");
    apb(1'b1, OFS_REG_SLEEP_CTL, 32'h3);
    core_op(1'b1);
    repeat (2) @(posedge pclk);
    #1;
    chk_bit(pwr_ctl.reg_low_power, 1'b1);
    @(posedge pclk);
    periph <= 3'b010;
    repeat (2) @(posedge pclk);
    #1;
    chk_bit(pwr_ctl.reg_low_power, 1'b0);
    @(posedge pclk);
    periph <= 3'b000;
    irq_wake();
    // low-power wake is later than a normal one by the settle count
    chk_word(32'(n), 32'(n0 + STAB));
    apb(1'b1, OFS_REG_SLEEP_CTL, 32'h1);
    $display("low-power sleep done");
    tick_on <= 1'b1;
    foreach (mt[i]) begin
      mode <= mt[i][3:2];
      apb(1'b1, OFS_WDT_CTL, {31'h0, mt[i][1]});
      core_op(1'b0);
      wait_ev(1, 200, 1'b0);
      chk_bit(got, mt[i][0]);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk_bit(rd[BIT_TIMEOUT], !mt[i][0]);
    end
    for (int m = 2; m <= 3; m++) begin
      mode <= m[1:0];
      core_op(1'b0);
      core_op(1'b1);
      wait_ev(0, 200, 1'b0);
      chk_bit(got, m == 3);
      if (!got) irq_wake();
      apb(1'b0, OFS_STATUS, 32'h0);
      chk_word(rd, (m == 3) ? 32'h0 : 32'h1);
    end
    mode <= WDT_MODE_OFF;
    $display("watchdog modes done");
    foreach (rs[i]) begin
      core_op(1'b1);
      @(posedge pclk);
      reset_src <= rs[i];
      wait_ev(2, 10, 1'b0);
      chk_bit(got, (rs[i][4] & rs[i][3]) | (rs[i][2] & rs[i][1]) | rs[i][0]);
      @(posedge pclk);
      reset_src <= '0;
      if (!got) irq_wake();
      #1;
      chk_bit(pwr_ctl.cpu_clk_en, 1'b1);
    end
    $display("reset sources done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    // in reset: no ready, cpu clock and oscillators on, pads free
    chk_word(32'({pready, pwr_ctl}), 32'h35);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_word(rd, 32'h3);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
